// ==== eea_access.sv ====
`timescale 1ns/1ps
// Contract
// R1 - Buffer up to 32 bytes, commit in one cycle; the code commits one byte per cycle over the first 32 timer cycles
// R2 - Extra data byte continues as page write
// R3 - Extra bytes advance only low five address bits
// R4 - In-page address wraps to page start
// R5 - Stop starts timed write; bus ignored meanwhile
// R6 - Busy: no acknowledge; idle: acknowledge write address
// R7 - Address counter holds last address plus one
// R8 - Read address byte: acknowledge, send counter byte
// R9 - Master no-acknowledge then stop ends read
// R10 - Read past last location wraps to zero
// R11 - Write counter wraps within the same page
// R12 - Power-up clears the address counter
// R13 - Over-page write leaves counter at given address
// R14 - Master: dummy write, repeated start, read
// R15 - Random read returns data at loaded address
// R16 - Master acknowledge advances and sends next byte
// R17 - Sequential read wraps to zero and continues
// R18 - Start, nine clocks, start abandon the command
// R19 - Master releases data line during dummy clocks
// R20 - Software reset ignored during internal write
// R21 - Respond only to matching code and select
// R22 - Acknowledge high then low memory address byte
// R23 - Write protect high blocks array writes only
// R24 - Ignore memory address bits above thirteen
module eea_access
   import eea_pkg::*;
#(
   parameter int         PROG_CNT = PROG_CYCLES,
   parameter logic [3:0] DEV_CODE = DEV_CODE_DFLT  // Arbitrary neutral value.
) (
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic rstn,
   // Two-wire bus; the data line is open drain.
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe,
   // Strap and protect pins.
   input  wire logic wp_i,
   input  wire logic upper_select_bit_i,
   // Status.
   output logic      busy
);

   localparam int TW = $clog2(PROG_CNT + 1);

   logic [1:0]         rst_sync_q;
   logic               rst_n;
   eea_pins_s          pin_raw;
   eea_pins_s          pin_s;
   logic               scl_prev_q;
   logic               sda_prev_q;
   eea_state_e         st_q;
   logic [3:0]         cnt_q;
   logic [7:0]         shift_q;
   logic [7:0]         tx_q;
   logic               oe_q;
   logic               ack_q;
   logic               mack_q;
   logic [4:0]         hi_q;
   logic [ADDR_W-1:0]  base_q;
   logic [ADDR_W-1:0]  cur_q;
   logic [PAGE_W-1:0]  idx_q;
   logic [5:0]         nbytes_q;
   logic [7:0]         buf_q [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] vld_q;
   logic [7:0]         mem_q [MEM_BYTES];
   logic               busy_q;
   logic               wp_lock_q;
   logic [TW-1:0]      tmr_q;

   // Reset is released through two flip-flops.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Every pin except rstn passes two flip-flops before any logic sees it.
   assign pin_raw = {scl_i, sda_i, wp_i, upper_select_bit_i};
   eea_sync #(.W($bits(eea_pins_s))) u_sync (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .d     (pin_raw),
      .q     (pin_s)
   );

   // Edge and condition detection on the synchronised copies.
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic byte_end;
   logic ack_end;
   logic dev_match;
   logic [7:0] rd_byte;
   logic [ADDR_W-1:0] addr_in;
   logic [ADDR_W-1:0] cur_next_page;
   logic mem_we;
   logic [PAGE_W-1:0] cidx;
   assign scl_rise  = pin_s.scl & ~scl_prev_q;
   assign scl_fall  = ~pin_s.scl & scl_prev_q;
   assign start_det = pin_s.scl & scl_prev_q & sda_prev_q & ~pin_s.sda;
   assign stop_det  = pin_s.scl & scl_prev_q & ~sda_prev_q & pin_s.sda;
   assign byte_end  = scl_fall & (cnt_q == LAST_BIT);
   assign ack_end   = scl_fall & ack_q;
   // Code, strap-selected bit and the two fixed select bits must all match.
   assign dev_match = (shift_q[7:4] == DEV_CODE) &&        // see R21
                      (shift_q[3] == pin_s.upper_select_bit) &&
                      (shift_q[2:1] == FIXED_SEL);
   assign rd_byte   = mem_q[cur_q];
   // Upper address bits beyond the array are dropped.
   assign addr_in   = {hi_q, shift_q};                      // see R24
   // Write counter advances inside the page only.
   assign cur_next_page = {cur_q[ADDR_W-1:PAGE_W],
                           PAGE_W'(cur_q[PAGE_W-1:0] + 5'h01)}; // see R11
   // Commit walks the page buffer during the first cycles of the timed write.
   assign cidx   = tmr_q[PAGE_W-1:0];
   assign mem_we = busy_q && (tmr_q < TW'(PAGE_BYTES)) && vld_q[cidx] &&
                   !wp_lock_q;                              // see R1, see R23
   assign sda_o  = 1'b0;
   assign sda_oe = oe_q;
   assign busy   = busy_q;

   // Previous sample for edge detection.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= pin_s.scl;
         sda_prev_q <= pin_s.sda;
      end
   end

   // Bit counter: rises one to eight carry data, the ninth is acknowledge.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
      end else if (start_det || stop_det) begin
         cnt_q <= 4'h0;
      end else if (scl_rise) begin
         cnt_q <= (cnt_q == LAST_BIT) ? 4'h0 : cnt_q + 4'h1;
      end
   end

   // Receive shifter samples on the clock rise while data bits flow.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= 8'h00;
         mack_q  <= 1'b0;
      end else if (scl_rise && cnt_q != LAST_BIT) begin
         shift_q <= {shift_q[6:0], pin_s.sda};
      end else if (scl_rise && st_q == ST_RDAT) begin
         mack_q  <= ~pin_s.sda;                             // see R16, see R9
      end else if (byte_end && st_q == ST_DEV) begin
         mack_q  <= 1'b1;
      end
   end

   // Protocol engine. Any start restarts addressing, which is also how the
   // software reset sequence abandons a half-sent command; the timed write
   // and the address counter are not touched by it.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q     <= ST_IDLE;
         oe_q     <= 1'b0;
         ack_q    <= 1'b0;
         tx_q     <= 8'h00;
         hi_q     <= 5'h00;
         base_q   <= CUR_RESET;
         cur_q    <= CUR_RESET;                             // see R12
         idx_q    <= '0;
         nbytes_q <= NBYTES_RESET;
         vld_q    <= '0;
      end else if (start_det || stop_det) begin
         st_q  <= start_det ? ST_DEV : ST_IDLE;             // see R18, see R9
         oe_q  <= 1'b0;
         ack_q <= 1'b0;
      end else if (byte_end) begin
         ack_q <= (st_q != ST_IDLE) && (st_q != ST_SKIP);
         case (st_q)
            ST_DEV: begin
               // A busy device stays silent, which is what polling sees.
               if (dev_match && !busy_q) begin              // see R6, see R5
                  oe_q <= 1'b1;
                  st_q <= shift_q[0] ? ST_RDAT : ST_AHI;    // see R8
               end else begin
                  ack_q <= 1'b0;
                  st_q  <= ST_SKIP;
               end
            end
            ST_AHI: begin
               hi_q <= shift_q[4:0];
               oe_q <= 1'b1;                                // see R22
               st_q <= ST_ALO;
            end
            ST_ALO: begin
               // The dummy write of a random read ends here.
               base_q   <= addr_in;
               cur_q    <= addr_in;                         // see R15, see R7
               idx_q    <= addr_in[PAGE_W-1:0];
               nbytes_q <= NBYTES_RESET;
               vld_q    <= '0;
               oe_q     <= 1'b1;                            // see R22
               st_q     <= ST_WDAT;
            end
            ST_WDAT: begin
               // Later bytes overwrite earlier ones once the index wraps.
               buf_q[idx_q] <= shift_q;                     // see R1, see R4
               vld_q[idx_q] <= 1'b1;
               idx_q        <= PAGE_W'(idx_q + 5'h01);      // see R2, see R3
               nbytes_q     <= (nbytes_q > 6'(PAGE_BYTES)) ? nbytes_q
                                                           : nbytes_q + 6'h01;
               cur_q        <= (nbytes_q >= 6'(PAGE_BYTES)) ? base_q
                                                            : cur_next_page; // see R13
               oe_q         <= 1'b1;
            end
            default: begin
               oe_q <= 1'b0;                                // Release the line; in a read the master acknowledges.
            end
         endcase
      end else if (ack_end) begin
         ack_q <= 1'b0;
         if (st_q == ST_RDAT && mack_q) begin
            // Load and present the first bit; counter wraps over the array.
            tx_q  <= rd_byte;                               // see R8, see R16
            oe_q  <= ~rd_byte[7];
            cur_q <= ADDR_W'(cur_q + 13'h0001);             // see R10, see R17
         end else if (st_q == ST_RDAT) begin
            oe_q <= 1'b0;
            st_q <= ST_SKIP;                                // see R9
         end else begin
            oe_q <= 1'b0;
         end
      end else if (scl_fall && st_q == ST_RDAT && cnt_q != 4'h0) begin
         tx_q <= {tx_q[6:0], 1'b0};
         oe_q <= ~tx_q[6];
      end
   end

   // Internal write timer. Bus traffic cannot cut it short.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_q    <= 1'b0;
         wp_lock_q <= 1'b0;
         tmr_q     <= '0;
      end else if (busy_q) begin
         tmr_q  <= TW'(tmr_q + 1'b1);                       // see R20
         busy_q <= (tmr_q != TW'(PROG_CNT - 1));
      end else if (stop_det && st_q == ST_WDAT && nbytes_q != NBYTES_RESET) begin
         busy_q    <= 1'b1;                                 // see R5
         wp_lock_q <= pin_s.wp;                             // see R23
         tmr_q     <= '0;
      end
   end

   // Array storage is nonvolatile in the real part, so it has no reset.
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         mem_q[{base_q[ADDR_W-1:PAGE_W], cidx}] <= buf_q[cidx]; // see R1
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_dev_end;
      byte_end && st_q == ST_DEV;
   endsequence

   sequence s_rd_load;
      ack_end && st_q == ST_RDAT && mack_q;
   endsequence

   sequence s_wr_byte;
      byte_end && st_q == ST_WDAT;
   endsequence

   busy_nack_a: assert property (s_dev_end and busy_q |=> !sda_oe && st_q == ST_SKIP) // see R6
      else $error("Busy device acknowledged an addressing byte.");

   dev_ack_a: assert property (s_dev_end and !busy_q && dev_match |=> sda_oe) // see R21
      else $error("Matching addressing byte was not acknowledged.");

   page_wrap_a: assert property (s_wr_byte |=> idx_q == PAGE_W'($past(idx_q) + 5'h01)
                                 && cur_q[ADDR_W-1:PAGE_W] == $past(cur_q[ADDR_W-1:PAGE_W])) // see R4
      else $error("Page write left its page.");

   over_page_a: assert property (s_wr_byte and nbytes_q >= 6'(PAGE_BYTES) |=> cur_q == base_q) // see R13
      else $error("Over-page write did not restore the given address.");

   commit_start_a: assert property ($rose(busy_q) |-> busy_q[*8] ##1 tmr_q == 8) // see R5
      else $error("Timed write did not start or run steadily.");

   busy_end_a: assert property (busy_q && tmr_q == TW'(PROG_CNT - 1) |=> !busy_q) // see R5
      else $error("Timed write did not end at its count.");

   read_next_a: assert property (s_rd_load |=> cur_q == ADDR_W'($past(cur_q) + 13'h0001)
                                 && tx_q == $past(rd_byte) && sda_oe == !tx_q[7]) // see R16
      else $error("Read did not present the counter byte.");

   read_stop_a: assert property (ack_end && st_q == ST_RDAT && !mack_q |=> st_q == ST_SKIP
                                 && !sda_oe) // see R9
      else $error("Read did not end on no-acknowledge.");

   start_reset_a: assert property (start_det |=> st_q == ST_DEV && cnt_q == 4'h0 && !sda_oe
                                   && (busy_q == $past(busy_q) ||
                                       $past(tmr_q) == TW'(PROG_CNT - 1))) // see R18
      else $error("Start did not restart addressing.");

endmodule : eea_access

// ==== eea_pkg.sv ====
package eea_pkg;

   // Clock period of the sampling clock, in nanoseconds.
   localparam int CLK_PERIOD_NS = 100;

   // Longest internal_program_time; the cycle count rounds down.
   localparam int T_PROG_NS    = 5000000;
   localparam int PROG_CYCLES  = T_PROG_NS / CLK_PERIOD_NS;

   // Array and page geometry.
   localparam int MEM_BYTES    = 8192;
   localparam int ADDR_W       = 13;
   localparam int PAGE_BYTES   = 32;
   localparam int PAGE_W       = 5;

   // Addressing byte fields.
   localparam logic [3:0] DEV_CODE_DFLT = 4'h6;  // Arbitrary neutral value.
   localparam logic [1:0] FIXED_SEL     = 2'h0;

   // Bit position of the acknowledge clock within a frame.
   localparam logic [3:0] LAST_BIT      = 4'h8;

   // Reset values.
   localparam logic [12:0] CUR_RESET    = 13'h0000;
   localparam logic [5:0]  NBYTES_RESET = 6'h00;

   // Pins sampled from outside the clock domain.
   typedef struct packed {
      logic scl;
      logic sda;
      logic wp;
      logic upper_select_bit;
   } eea_pins_s;

   // Command states, Gray coded along the usual path.
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DEV  = 3'h1,
      ST_AHI  = 3'h3,
      ST_ALO  = 3'h2,
      ST_WDAT = 3'h6,
      ST_RDAT = 3'h7,
      ST_SKIP = 3'h5
   } eea_state_e;

endpackage : eea_pkg

// ==== eea_sync.sv ====
`timescale 1ns/1ps
module eea_sync
   import eea_pkg::*;
#(
   parameter int W = 4
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Asynchronous levels in, synchronised levels out.
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);

   logic [W-1:0] meta_q;

   // Two flip-flops; the first stage feeds only the second.
   always_ff @(posedge clk or negedge rst_n) begin
      // Reset to the idle bus level, so no false edge follows reset.
      if (!rst_n) begin
         meta_q <= '1;
         q      <= '1;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : eea_sync

// ==== eea_mstr.sv ====
`timescale 1ns/1ps
// Bus master model; it only ever pulls the data line low, never drives it high.
module eea_mstr (
   // Clock that paces the bus.
   input  wire logic clk,
   // Wire level of the data line.
   input  wire logic sda,
   // Bus outputs.
   output logic      scl,
   output logic      sda_low
);
   // Idle bus: clock stands high and data is released.
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   // Wait a number of clock edges.
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask : w
   // One bit, 400 ns low and 400 ns high; the wire is read in mid high phase.
   task automatic bit_io(input logic b, output logic s);
      scl <= 1'b0;
      w(2);
      sda_low <= ~b;
      w(2);
      scl <= 1'b1;
      w(2);
      #1 s = sda;
      w(2);
   endtask : bit_io
   // Start; the long low phase lets the device let go of the line first.
   task automatic start();
      scl <= 1'b0;
      w(3);
      sda_low <= 1'b0;
      w(3);
      scl <= 1'b1;
      w(4);
      sda_low <= 1'b1;
      w(4);
   endtask : start
   // Stop, leaving the bus idle.
   task automatic stop();
      scl <= 1'b0;
      w(3);
      sda_low <= 1'b1;
      w(3);
      scl <= 1'b1;
      w(4);
      sda_low <= 1'b0;
      w(4);
   endtask : stop
   // Byte out, most significant bit first; ack is the wire level in the ninth slot.
   task automatic wbyte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], ack);
      end
      bit_io(1'b1, ack);
   endtask : wbyte
   // Byte in with the line released; mack is sent back in the ninth slot.
   task automatic rbyte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(mack, s);
   endtask : rbyte
   // Reset sequence; the line stays released since the device may still drive it.
   task automatic swrst();
      logic s;
      start();
      for (int i = 0; i < 9; i++) begin
         bit_io(1'b1, s);
      end
      start();
   endtask : swrst
endmodule : eea_mstr

// ==== eea_access_bench.sv ====
`timescale 1ns/1ps
module eea_access_bench
   import eea_pkg::*;
;
   // Short write timer so the run stays brief; a poll right after a stop still sees it.
   localparam int PCNT = 200;
   logic        clk_sys, rstn, wp_i, usb, scl, sda_low, sda, sda_oe, busy, ak;
   logic [12:0] a2;
   logic [31:0] lfsr;
   logic [7:0]  mdl [MEM_BYTES];
   int          error_cnt = 0;
   int          n_compared = 0;

   // Open-drain wire with its pull-up.
   assign sda = (sda_low | sda_oe) ? 1'b0 : 1'b1;

   eea_access #(.PROG_CNT(PCNT)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .scl_i(scl),
      .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .wp_i(wp_i), .upper_select_bit_i(usb),
      .busy(busy));
   eea_mstr m_u (.clk(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));

   // System clock.
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Random bytes from a shift register with a fixed start.
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   task automatic rnd(output logic [7:0] b);
      repeat (8) lfsr = nxt(lfsr);
      b = lfsr[7:0];
   endtask : rnd
   // Addressing byte and in-page step.
   function automatic logic [7:0] dev(input logic rw);
      return {DEV_CODE_DFLT, usb, FIXED_SEL, rw};
   endfunction : dev
   function automatic logic [12:0] pg(input logic [12:0] a, input int k);
      return {a[12:5], a[4:0] + k[4:0]};
   endfunction : pg

   // Compare and count.
   task automatic check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask : done
   // Dummy write that loads the address; upper bits of the high byte are junk on purpose.
   task automatic seta(input logic [12:0] a);
      m_u.start();
      m_u.wbyte(dev(1'b0), ak);
      check("ack dev", {12'h000, ak}, 13'h0000);
      m_u.wbyte({3'h7, a[12:8]}, ak);
      check("ack hi", {12'h000, ak}, 13'h0000);
      m_u.wbyte(a[7:0], ak);
      check("ack lo", {12'h000, ak}, 13'h0000);
   endtask : seta
   // Page write of n random bytes; the model skips them while protected.
   task automatic wr(input logic [12:0] a, input int n);
      logic [7:0] b;
      seta(a);
      for (int k = 0; k < n; k++) begin
         rnd(b);
         m_u.wbyte(b, ak);
         check("ack data", {12'h000, ak}, 13'h0000);
         if (!wp_i) begin
            mdl[pg(a, k)] = b;
         end
      end
      m_u.stop();
      @(negedge clk_sys);
      check("busy on", {12'h000, busy}, 13'h0001);
   endtask : wr
   // Wait out the timed write.
   task automatic wait_done();
      repeat (PCNT + 40) @(posedge clk_sys);
      @(negedge clk_sys);
      check("busy off", {12'h000, busy}, 13'h0000);
   endtask : wait_done
   // Acknowledge poll with a write addressing byte.
   task automatic poll(input logic exp);
      m_u.start();
      m_u.wbyte(dev(1'b0), ak);
      check("poll ack", {12'h000, ak}, {12'h000, exp});
      m_u.stop();
   endtask : poll
   // Current address read of n bytes, expected to start at a.
   task automatic rd_chk(input logic [12:0] a, input int n);
      logic [7:0] d;
      m_u.start();
      m_u.wbyte(dev(1'b1), ak);
      check("ack read", {12'h000, ak}, 13'h0000);
      for (int k = 0; k < n; k++) begin
         m_u.rbyte(k == n - 1, d);
         check("read data", {5'h00, d}, {5'h00, mdl[a]});
         a = a + 13'h0001;
      end
      m_u.stop();
   endtask : rd_chk
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   // Test sequence.
   initial begin
      logic [7:0] b;
      lfsr = 32'h89DB3798;
      rnd(b);
      usb  <= b[0];
      wp_i <= 1'b0;
      rstn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      check("idle oe", {12'h000, sda_oe}, 13'h0000);
      check("idle busy", {12'h000, busy}, 13'h0000);
      done("reset");
      // More than a page: later bytes replace earlier ones, counter returns.
      rnd(b);
      a2[12:5] = b;
      rnd(b);
      a2[4:0] = b[4:0];
      wr(a2, 35);
      wait_done();
      rd_chk(a2, 1);
      done("over page");
      // In-page wrap near the page end, then polling.
      wr({a2[12:5], 5'h1D}, 5);
      poll(1'b1);
      wait_done();
      poll(1'b0);
      rd_chk(pg({a2[12:5], 5'h1D}, 5), 2);
      done("wrap and poll");
      // Last location and zero, read across the end of the array.
      wr(13'h1FFF, 1);
      wait_done();
      wr(13'h0000, 1);
      wait_done();
      seta(13'h1FFF);
      rd_chk(13'h1FFF, 1);
      rd_chk(13'h0000, 1);
      seta(13'h1FFF);
      rd_chk(13'h1FFF, 2);
      done("array wrap");
      // Protected write leaves the array alone.
      @(posedge clk_sys);
      wp_i <= 1'b1;
      wr(a2, 1);
      wait_done();
      @(posedge clk_sys);
      wp_i <= 1'b0;
      seta(a2);
      rd_chk(a2, 1);
      done("protect");
      // Foreign select, then a half command cut by the reset sequence.
      m_u.start();
      m_u.wbyte({DEV_CODE_DFLT, ~usb, FIXED_SEL, 1'b0}, ak);
      check("ack other", {12'h000, ak}, 13'h0001);
      m_u.stop();
      m_u.start();
      m_u.wbyte(dev(1'b0), ak);
      m_u.wbyte(8'h00, ak);
      m_u.swrst();
      seta(a2);
      rd_chk(a2, 1);
      done("select and reset");
      give_verdict();
   end

   // Watchdog, well beyond the expected length of the run.
   initial begin
      repeat (40000) @(posedge clk_sys);
      error_cnt++;
      give_verdict();
   end
endmodule : eea_access_bench
